// ==== cmm_io_map.svh ====
// register offsets, field positions, reset values and timing counts of the machine I/O interlock
// assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus
`ifndef CMM_IO_MAP_SVH
`define CMM_IO_MAP_SVH
// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_MHZ        100
`define CFB_DELAY_MS   100
`define FILT_TIME_NS   2000
`define FILT_CYC       ((`FILT_TIME_NS * `CLK_MHZ + 999) / 1000)
// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFF_CTRL       8'h00
`define OFF_GPOUT      8'h04
`define OFF_GPIN       8'h08
`define OFF_STATUS     8'h0C
`define OFF_EVENT      8'h10
`define OFF_CFB_TMO    8'h14
`define OFF_INNER_EN   8'h18
`define OFF_LIMITS     8'h1C
// ----------------------------------------------------------------------------
// reset values, input vector positions, event bits, bus answers
// ----------------------------------------------------------------------------
`define RST_CTRL       1'h0
`define RST_GPOUT      7'h00
`define RST_INNER_EN   6'h3F
`define BIT_ESTOP      0
`define BIT_AIR        1
`define BIT_CRASH      2
`define BIT_CFB        3
`define BIT_AMP        4
`define BIT_DETACH     5
`define BIT_OUTER      6
`define BIT_INNER      12
`define BIT_GPIN       18
`define EV_ESTOP       0
`define EV_AIR         1
`define EV_CRASH       2
`define EV_CFB         3
`define EV_OUTER       4
`define EV_INNER       5
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// ==== cmm_io_pkg.sv ====
// types shared by the machine I/O interlock modules
// assumes nothing beyond a SystemVerilog compiler
package cmm_io_pkg;
    // motor power sequence: contactor first, then amplifiers, then servo run
    typedef enum logic [1:0] {DRV_OFF, DRV_CONTACT, DRV_AMP, DRV_RUN} drive_state_t;
endpackage

// ==== reg_bus_if.sv ====
// register access strobes between the bus slave and the register file
// assumes one clock; strobes last one cycle and read data is combinational
`timescale 1ns/1ps
interface reg_bus_if;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_err;
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_err;
    modport bus_side (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                      input wr_err, rd_data, rd_err);
    modport reg_side (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                      output wr_err, rd_data, rd_err);
endinterface // reg_bus_if

// ==== input_filter.sv ====
// synchroniser and glitch filter for the active-low machine inputs
// assumes inputs may bounce; a level must hold FILT_CYC cycles to be accepted
`timescale 1ns/1ps
`include "cmm_io_map.svh"
module input_filter (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [23:0] raw,
    output logic      [23:0] flt
);
    localparam logic [7:0] FILT_MAX = 8'(`FILT_CYC - 1);

    // one filter per input; reset shows every input open, the unsafe level
    for (genvar i = 0; i < 24; i++) begin : g_bit
        logic       s1;
        logic       s2;
        logic [7:0] cnt;
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                s1     <= 1'h1;
                s2     <= 1'h1;
                cnt    <= 8'h00;
                flt[i] <= 1'h1;
            end else begin
                s1 <= raw[i];
                s2 <= s1;
                if (s2 == flt[i]) begin
                    cnt <= 8'h00;
                end else if (cnt == FILT_MAX) begin
                    flt[i] <= s2; // [RL21]
                    cnt    <= 8'h00;
                end else begin
                    cnt <= cnt + 8'h01;
                end
            end
        end
    end
endmodule // input_filter

// ==== axi_lite_slave.sv ====
// AXI4-Lite slave front end: one write and one read in flight at most
// assumes the register file answers reads combinationally in the strobe cycle
`timescale 1ns/1ps
`include "cmm_io_map.svh"
module axi_lite_slave (
    input  wire logic        clk,
    input  wire logic        reset_n,
    reg_bus_if.bus_side      bus,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);
    // a channel's ready drops once its item is held, and returns after the answer
    assign bus.wr_en   = !awready && !wready && !bvalid;
    assign bus.rd_en   = !arready && !rvalid;

    // ------------------------------------------------------------------------
    // write channels
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            awready     <= 1'h1;
            wready      <= 1'h1;
            bvalid      <= 1'h0;
            bresp       <= `RESP_OKAY;
            bus.wr_addr <= 8'h00;
            bus.wr_data <= 32'h0;
            bus.wr_strb <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                bus.wr_addr <= awaddr;
                awready     <= 1'h0;
            end
            if (wvalid && wready) begin
                bus.wr_data <= wdata;
                bus.wr_strb <= wstrb;
                wready      <= 1'h0;
            end
            if (bus.wr_en) begin
                bvalid <= 1'h1;
                bresp  <= bus.wr_err ? `RESP_SLVERR : `RESP_OKAY;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'h0;
                awready <= 1'h1;
                wready  <= 1'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // read channels
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            arready     <= 1'h1;
            rvalid      <= 1'h0;
            rresp       <= `RESP_OKAY;
            rdata       <= 32'h0;
            bus.rd_addr <= 8'h00;
        end else begin
            if (arvalid && arready) begin
                bus.rd_addr <= araddr;
                arready     <= 1'h0;
            end
            if (bus.rd_en) begin
                rvalid <= 1'h1;
                rdata  <= bus.rd_data;
                rresp  <= bus.rd_err ? `RESP_SLVERR : `RESP_OKAY;
            end
            if (rvalid && rready) begin
                rvalid  <= 1'h0;
                arready <= 1'h1;
            end
        end
    end
endmodule // axi_lite_slave

// ==== cmm_machine_io_interlock.sv ====
// machine I/O interlock: filtered safety inputs, motor power sequence, general I/O
// assumes active-low machine inputs asynchronous to CLK and an AXI4-Lite master
//
// Notes on behaviour
// RL1 - a control bit of one turns its general output transistor on
// RL2 - general inputs read zero when pulled low, one when high or open
// RL3 - machine pulls amplifier-ready low once every amplifier is enabled
// RL4 - detached drives, input high or open, never get driven
// RL5 - on re-clutch, servo resumes holding the present position
// RL6 - motors may energise only while emergency stop reads low
// RL7 - emergency stop high disables and refuses motors and flags the host
// RL8 - air pressure not low disables motors and flags the host
// RL9 - unused air monitoring is tied permanently low by the machine
// RL10 - crash input not low disables motors and flags the host
// RL11 - machine pulls contactor feedback low while motor power is present
// RL12 - missing contactor feedback after a delay disables motors and flags host
// RL13 - drives engage only while every outer limit is closed
// RL14 - inner limit stops all axes, backs off offender, then holds
// RL15 - any outer limit disengages all servo drive motors
// RL16 - limit stopping follows host-programmed settings over twelve inputs; here only the six inner limits are host-enabled
// RL17 - one contactor output conducts exactly while motors should energise
// RL18 - one amplifier enable conducts exactly while amplifiers should energise
// RL19 - every machine input is low when safe; high or open means fault
// RL20 - contactor feedback timeout is a host-set cycle count from switch-on
// RL21 - inputs are synchronised and filtered before any interlock decision
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "cmm_io_map.svh"
module cmm_machine_io_interlock
    import cmm_io_pkg::*;
#(
    parameter int unsigned CFB_TMO_CYC = `CFB_DELAY_MS * 1000 * `CLK_MHZ
) (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    input  wire logic        ESTOP_IN,
    input  wire logic        AIR_IN,
    input  wire logic        CRASH_IN,
    input  wire logic        CONTACTOR_FB_IN,
    input  wire logic        AMP_READY_IN,
    input  wire logic        DRIVE_DETACHED_INPUT,
    input  wire logic [5:0]  OUTER_LIMIT_IN,
    input  wire logic [5:0]  INNER_LIMIT_IN,
    input  wire logic [5:0]  GP_IN,
    output logic [6:0]       GP_OUT_ON,
    output logic             CONTACTOR_ON,
    output logic             AMP_ENABLE,
    output logic             DRIVE_ENABLE,
    output logic             HOLD_AT_POSITION,
    output logic             STOP_ALL_AXES,
    output logic [5:0]       BACKOFF_SWITCH
);
    // ------------------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------------------
    logic [23:0] raw;
    logic [23:0] flt;
    // bit order follows the BIT_ defines
    assign raw = {GP_IN, INNER_LIMIT_IN, OUTER_LIMIT_IN, DRIVE_DETACHED_INPUT,
                  AMP_READY_IN, CONTACTOR_FB_IN, CRASH_IN, AIR_IN, ESTOP_IN};

    input_filter u_filter (
        .clk     (CLK),
        .reset_n (RESET_N),
        .raw     (raw),
        .flt     (flt)
    );

    // a high level is the fault or open state on every input
    wire       estop  = flt[`BIT_ESTOP]; // [RL19]
    wire       air    = flt[`BIT_AIR];
    wire       crash  = flt[`BIT_CRASH];
    wire       cfb    = flt[`BIT_CFB];
    wire       amp_nr = flt[`BIT_AMP];
    wire       detach = flt[`BIT_DETACH];
    wire [5:0] outer  = flt[`BIT_OUTER +: 6];
    wire [5:0] inner  = flt[`BIT_INNER +: 6];
    wire [5:0] gpin   = flt[`BIT_GPIN +: 6];

    // ------------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------------
    // strobes last one cycle each
    reg_bus_if bus ();

    axi_lite_slave u_axi (
        .clk     (CLK),
        .reset_n (RESET_N),
        .bus     (bus.bus_side),
        .awaddr  (AWADDR),
        .awvalid (AWVALID),
        .awready (AWREADY),
        .wdata   (WDATA),
        .wstrb   (WSTRB),
        .wvalid  (WVALID),
        .wready  (WREADY),
        .bresp   (BRESP),
        .bvalid  (BVALID),
        .bready  (BREADY),
        .araddr  (ARADDR),
        .arvalid (ARVALID),
        .arready (ARREADY),
        .rdata   (RDATA),
        .rresp   (RRESP),
        .rvalid  (RVALID),
        .rready  (RREADY)
    );

    // ------------------------------------------------------------------------
    // registers and write decode
    // ------------------------------------------------------------------------
    drive_state_t state;
    drive_state_t next_state;
    logic         drive_req;
    logic [31:0]  cfb_tmo;
    logic [31:0]  cfb_cnt;
    logic [5:0]   inner_en;
    logic [5:0]   events;
    logic         detach_d;

    // narrow registers use lane 0 only
    wire wr_ctrl  = bus.wr_en && bus.wr_addr == `OFF_CTRL && bus.wr_strb[0];
    wire wr_gpout = bus.wr_en && bus.wr_addr == `OFF_GPOUT && bus.wr_strb[0];
    wire wr_event = bus.wr_en && bus.wr_addr == `OFF_EVENT && bus.wr_strb[0];
    wire wr_tmo   = bus.wr_en && bus.wr_addr == `OFF_CFB_TMO;
    wire wr_inen  = bus.wr_en && bus.wr_addr == `OFF_INNER_EN && bus.wr_strb[0];
    wire addr_ok  = bus.wr_addr inside {`OFF_CTRL, `OFF_GPOUT, `OFF_GPIN,
                    `OFF_STATUS, `OFF_EVENT, `OFF_CFB_TMO, `OFF_INNER_EN, `OFF_LIMITS};
    wire rd_ok    = bus.rd_addr inside {`OFF_CTRL, `OFF_GPOUT, `OFF_GPIN,
                    `OFF_STATUS, `OFF_EVENT, `OFF_CFB_TMO, `OFF_INNER_EN, `OFF_LIMITS};
    assign bus.wr_err = !addr_ok;
    assign bus.rd_err = !rd_ok;

    // byte-lane merge for the one wide register
    logic [31:0] next_cfb_tmo;
    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign next_cfb_tmo[8*b +: 8] = (wr_tmo && bus.wr_strb[b]) ?
                                        bus.wr_data[8*b +: 8] : cfb_tmo[8*b +: 8];
    end

    // ------------------------------------------------------------------------
    // interlock decisions
    // ------------------------------------------------------------------------
    // contactor counted from switch-on; afterwards feedback must stay low
    wire cfb_late = state == DRV_CONTACT && cfb && cfb_cnt >= cfb_tmo; // [RL12] [RL20]
    wire cfb_lost = (state == DRV_AMP || state == DRV_RUN) && cfb;
    wire cfb_fail = cfb_late || cfb_lost;
    wire outer_any = |outer; // [RL15]
    wire [5:0] inner_hit = inner & inner_en; // [RL16]
    wire fault_now = estop || air || crash || outer_any || cfb_fail; // [RL7] [RL8] [RL10]
    // engaging also needs every outer switch closed and no emergency stop
    wire permit = !estop && !air && !crash && !outer_any; // [RL6] [RL13]
    // a dropped request also powers down
    wire halt = fault_now || !drive_req;
    wire [5:0] ev_set = {|inner_hit, outer_any, cfb_fail, crash, air, estop};
    wire [5:0] ev_clr = wr_event ? bus.wr_data[5:0] : 6'h00;
    // a fault drops the request so software must ask again; the kill beats a write
    wire next_drive_req = fault_now ? 1'h0 : (wr_ctrl ? bus.wr_data[0] : drive_req);

    // motor power sequence
    always_comb begin
        next_state = state;
        unique case (state)
            DRV_OFF:     if (drive_req && permit) next_state = DRV_CONTACT;
            DRV_CONTACT: if (halt) next_state = DRV_OFF;
                         else if (!cfb) next_state = DRV_AMP;
            DRV_AMP:     if (halt) next_state = DRV_OFF;
                         else if (!amp_nr) next_state = DRV_RUN; // [RL3]
            DRV_RUN:     if (halt) next_state = DRV_OFF;
        endcase
    end

    // ------------------------------------------------------------------------
    // state, registers and outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state     <= DRV_OFF;
            drive_req <= `RST_CTRL;
            GP_OUT_ON <= `RST_GPOUT;
            cfb_tmo   <= 32'(CFB_TMO_CYC);
            inner_en  <= `RST_INNER_EN;
            events    <= 6'h00;
            cfb_cnt   <= 32'h0;
            detach_d  <= 1'h1;
        end else begin
            state     <= next_state;
            drive_req <= next_drive_req;
            cfb_tmo   <= next_cfb_tmo;
            detach_d  <= detach;
            if (wr_gpout) GP_OUT_ON <= bus.wr_data[6:0]; // [RL1]
            if (wr_inen) inner_en <= bus.wr_data[5:0];
            events    <= ev_set | (events & ~ev_clr); // set wins over clear
            if (state != DRV_CONTACT) cfb_cnt <= 32'h0; // [RL20]
            else if (cfb_cnt != 32'hFFFFFFFF) cfb_cnt <= cfb_cnt + 32'h1;
        end
    end

    // power outputs follow the next state so a fault opens them one edge later
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            CONTACTOR_ON     <= 1'h0;
            AMP_ENABLE       <= 1'h0;
            DRIVE_ENABLE     <= 1'h0;
            HOLD_AT_POSITION <= 1'h0;
            STOP_ALL_AXES    <= 1'h0;
            BACKOFF_SWITCH   <= 6'h00;
        end else begin
            CONTACTOR_ON     <= next_state != DRV_OFF; // [RL17]
            AMP_ENABLE       <= next_state inside {DRV_AMP, DRV_RUN}; // [RL18]
            DRIVE_ENABLE     <= next_state == DRV_RUN && !detach; // [RL4]
            HOLD_AT_POSITION <= state == DRV_RUN && next_state == DRV_RUN
                                && detach_d && !detach; // [RL5]
            STOP_ALL_AXES    <= |inner_hit; // [RL14]
            BACKOFF_SWITCH   <= inner_hit;
        end
    end

    // ------------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------------
    // unmapped reads return zero
    wire [31:0] status = {22'h0, 2'(state), 2'h0, flt[5:0]};
    assign bus.rd_data =
        (bus.rd_addr == `OFF_CTRL)     ? {31'h0, drive_req} :
        (bus.rd_addr == `OFF_GPOUT)    ? {25'h0, GP_OUT_ON} :
        (bus.rd_addr == `OFF_GPIN)     ? {26'h0, gpin} : // [RL2]
        (bus.rd_addr == `OFF_STATUS)   ? status :
        (bus.rd_addr == `OFF_EVENT)    ? {26'h0, events} :
        (bus.rd_addr == `OFF_CFB_TMO)  ? cfb_tmo :
        (bus.rd_addr == `OFF_INNER_EN) ? {26'h0, inner_en} :
        (bus.rd_addr == `OFF_LIMITS)   ? {20'h0, inner, outer} : 32'h0;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    a_gpout_write: assert property (wr_gpout |=> GP_OUT_ON == $past(bus.wr_data[6:0])) // [RL1]
        else $error("general output not updated by write");
    a_gpin_read: assert property (bus.rd_en && bus.rd_addr == `OFF_GPIN
        |=> RVALID && RDATA[5:0] == $past(gpin)) // [RL2]
        else $error("general input read wrong");
    a_detach_nodrive: assert property (detach |=> !DRIVE_ENABLE) // [RL4]
        else $error("motors driven while detached");
    a_reclutch_hold: assert property ($fell(detach) && state == DRV_RUN && next_state == DRV_RUN
        |=> HOLD_AT_POSITION ##1 !HOLD_AT_POSITION) // [RL5]
        else $error("no single hold pulse on re-clutch");
    a_estop_gate: assert property ($rose(CONTACTOR_ON) |-> $past(!estop)) // [RL6]
        else $error("motors energised during emergency stop");
    a_estop_off: assert property (estop |=> !CONTACTOR_ON && !AMP_ENABLE
        && events[`EV_ESTOP]) // [RL7]
        else $error("emergency stop not obeyed");
    a_air_off: assert property (air |=> !CONTACTOR_ON && events[`EV_AIR]) // [RL8]
        else $error("low air not obeyed");
    a_crash_off: assert property (crash |=> !CONTACTOR_ON && events[`EV_CRASH]) // [RL10]
        else $error("crash not obeyed");
    a_cfb_timeout: assert property (cfb_late |=> state == DRV_OFF
        && !CONTACTOR_ON && events[`EV_CFB]) // [RL12]
        else $error("contactor timeout not obeyed");
    a_outer_closed: assert property ($rose(CONTACTOR_ON) |-> $past(outer == 6'h00)) // [RL13]
        else $error("drives engaged with an outer limit open");
    a_inner_stop: assert property (|inner_hit |=> STOP_ALL_AXES
        && BACKOFF_SWITCH == $past(inner_hit)) // [RL14]
        else $error("inner limit not stopped");
    a_outer_off: assert property (outer_any |=> !CONTACTOR_ON && !DRIVE_ENABLE) // [RL15]
        else $error("outer limit did not disengage");
    a_amp_order: assert property ($rose(AMP_ENABLE) |-> CONTACTOR_ON
        && $past(state == DRV_CONTACT && !cfb)) // [RL18]
        else $error("amplifiers enabled out of sequence");
    // request kill, counter rest and drive only in run
    a_fault_kill: assert property (fault_now |=> !drive_req) // [RL7]
        else $error("request kept after fault");
    a_cnt_rest: assert property (state != DRV_CONTACT |=> cfb_cnt == 32'h0) // [RL20]
        else $error("counter not at rest");
    a_drive_run: assert property (DRIVE_ENABLE |-> state == DRV_RUN) // [RL6]
        else $error("drive outside run");

    // bench scenarios
    c_run: cover property (state == DRV_AMP ##1 state == DRV_RUN);
    c_cfb_fail: cover property (cfb_late);
    c_reclutch: cover property (HOLD_AT_POSITION);
    c_inner: cover property (STOP_ALL_AXES && CONTACTOR_ON);
    c_kill: cover property (fault_now && drive_req);
endmodule // cmm_machine_io_interlock

// ==== machine_model.sv ====
// machine side: contactor feedback and amplifier-ready answers
// assumes active-low feedback lines; fb_en low models a dead contactor
`timescale 1ns/1ps
module machine_model (
    input  wire logic clk,
    input  wire logic contactor_on,
    input  wire logic amp_enable,
    input  wire logic fb_en,
    output logic      contactor_fb_n,
    output logic      amp_ready_n
);
    logic [3:0] c_d = 4'h0;
    logic [3:0] a_d = 4'h0;
    // a few cycles of relay and amplifier lag, so answers are never instant
    always @(posedge clk) begin
        c_d <= {c_d[2:0], contactor_on & fb_en};
        a_d <= {a_d[2:0], amp_enable};
    end
    assign contactor_fb_n = ~c_d[3];
    assign amp_ready_n    = ~a_d[3];
endmodule // machine_model

// ==== tb_top.sv ====
// self-checking bench for the machine I/O interlock
// assumes 200-cycle input filter; waits of 210 cycles let levels settle
`timescale 1ns/1ps
`include "cmm_io_map.svh"
module tb_top;
    import cmm_io_pkg::*;
    // ------------------------------------------------------------
    // stimulus, wiring and tasks
    // ------------------------------------------------------------
    logic clk = 0, reset_n = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic fb_en = 1, estop = 0, crash = 0, det = 0;
    logic air = 0; // held low while the air test is not running
    logic awr, wrd, bv, arr, rv, cfb_n, amp_n, con, amp, drv, hold, stop;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, q, rdata;
    logic [1:0] r, bresp, rresp;
    logic [5:0] outer = 0, inner = 0, gpi = 0, back;
    logic [6:0] gpo;
    int n_fail = 0, n_checks = 0, cyc = 0, n_hold = 0, n_con = 0, i, e;
    int seed = 32'hBC762E80;
    int evb[4] = '{`EV_ESTOP, `EV_AIR, `EV_CRASH, `EV_OUTER};
    cmm_machine_io_interlock #(.CFB_TMO_CYC(400)) i_cmm_machine_io_interlock (
        .CLK(clk), .RESET_N(reset_n), .AWADDR(awaddr), .AWVALID(awv), .AWREADY(awr),
        .WDATA(wdata), .WSTRB(4'hF), .WVALID(wv), .WREADY(wrd), .BRESP(bresp),
        .BVALID(bv), .BREADY(bready), .ARADDR(araddr), .ARVALID(arv), .ARREADY(arr),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rv), .RREADY(rready), .ESTOP_IN(estop),
        .AIR_IN(air), .CRASH_IN(crash), .CONTACTOR_FB_IN(cfb_n), .AMP_READY_IN(amp_n),
        .DRIVE_DETACHED_INPUT(det), .OUTER_LIMIT_IN(outer), .INNER_LIMIT_IN(inner),
        .GP_IN(gpi), .GP_OUT_ON(gpo), .CONTACTOR_ON(con), .AMP_ENABLE(amp),
        .DRIVE_ENABLE(drv), .HOLD_AT_POSITION(hold), .STOP_ALL_AXES(stop),
        .BACKOFF_SWITCH(back));
    machine_model i_machine_model (.clk(clk), .contactor_on(con), .amp_enable(amp),
        .fb_en(fb_en), .contactor_fb_n(cfb_n), .amp_ready_n(amp_n));
    initial forever #5 clk = ~clk;
    // pre-edge values are read here, so one-cycle pulses are never missed
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (hold === 1'b1) n_hold = n_hold + 1;
        if (con === 1'b1) n_con = n_con + 1;
        if (cyc == 30000) begin
            n_fail = n_fail + 1;
            close_out;
        end
    end
    task close_out;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, g, x);
        end
    endtask
    task idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one bus transfer; handshakes sampled mid-cycle, released after the edge
    task bus(input bit w, input [7:0] a, input [31:0] d, output [31:0] o,
             output [1:0] s);
        bit ha, hw, hd;
        @(posedge clk);
        if (w) begin
            awaddr <= a; awv <= 1; wdata <= d; wv <= 1; bready <= 1;
        end else begin
            araddr <= a; arv <= 1; rready <= 1;
        end
        hd = 0;
        while (!hd) begin
            @(negedge clk);
            ha = w ? awv & awr : arv & arr;
            hw = wv & wrd;
            hd = w ? bv : rv;
            o = rdata;
            s = w ? bresp : rresp;
            @(posedge clk);
            if (ha) begin awv <= 0; arv <= 0; end
            if (hw) wv <= 0;
            if (hd) begin bready <= 0; rready <= 0; end
        end
    endtask
    task go;
        bus(1, `OFF_CTRL, 1, q, r);
        chk(r, `RESP_OKAY);
        idle(460);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        idle(16);
        @(posedge clk) reset_n <= 1;
        idle(215);
        bus(1, `OFF_EVENT, 32'h3F, q, r);
        for (i = 0; i < 4; i++) begin
            e = $random(seed);
            @(posedge clk) gpi <= 6'($random(seed));
            bus(1, `OFF_GPOUT, e, q, r);
            idle(1);
            chk(gpo, e[6:0]);
            idle(210);
            bus(0, `OFF_GPIN, 0, q, r);
            chk(q, gpi);
        end
        $display("test gpio done");
        go;
        chk({con, amp, drv}, 3'h7);
        bus(0, `OFF_STATUS, 0, q, r);
        chk(q[9:8], DRV_RUN);
        @(posedge clk) estop <= 1;
        idle(50);
        @(posedge clk) estop <= 0;
        idle(5);
        chk(drv, 1);
        @(posedge clk) det <= 1;
        idle(210);
        chk({con, drv}, 2'h2);
        n_hold = 0;
        @(posedge clk) det <= 0;
        idle(210);
        chk(n_hold, 1);
        $display("test drive done");
        for (i = 0; i < 4; i++) begin
            go;
            e = {$random(seed)} % 6;
            @(posedge clk) case (i) 0: estop <= 1; 1: air <= 1; 2: crash <= 1;
                default: outer[e] <= 1; endcase
            idle(210);
            chk({con, amp, drv}, 0);
            bus(1, `OFF_CTRL, 1, q, r);
            idle(20);
            chk(con, 0);
            bus(0, `OFF_EVENT, 0, q, r);
            chk(q[evb[i]], 1);
            @(posedge clk) {estop, air, crash, outer} <= 0;
            idle(210);
            bus(1, `OFF_EVENT, 32'h3F, q, r);
        end
        $display("test faults done");
        bus(1, `OFF_CFB_TMO, 300, q, r);
        bus(0, `OFF_CFB_TMO, 0, q, r);
        chk(q, 300);
        @(posedge clk) fb_en <= 0;
        n_con = 0;
        bus(1, `OFF_CTRL, 1, q, r);
        idle(400);
        chk(n_con >= 300 && n_con <= 303, 1);
        bus(0, `OFF_EVENT, 0, q, r);
        chk(q[`EV_CFB], 1);
        $display("test feedback done");
        @(posedge clk) inner <= 6'h04;
        idle(210);
        chk({stop, back}, 7'h44);
        bus(1, `OFF_INNER_EN, 32'h3B, q, r);
        idle(3);
        chk({stop, back}, 0);
        bus(0, 8'h40, 0, q, r);
        chk(r, `RESP_SLVERR);
        chk(q, 0);
        $display("test limits and map done");
        close_out;
    end
endmodule // tb_top
